// *** common/cmsc_map.vh ***
// register map, field layout, mode and coding codes, reset values of the symbol coder
`ifndef CMSC_MAP_VH
`define CMSC_MAP_VH

// register byte offsets (low address byte)
`define CMSC_OFF_CTRL     8'h00
`define CMSC_OFF_STAT     8'h04
`define CMSC_OFF_DEV      8'h08
`define CMSC_OFF_CNT      8'h0C
`define CMSC_VDEV_BASE    3'h2
`define CMSC_USER_BASE    2'h2

// control register fields
`define CMSC_CTRL_PM      1
`define CMSC_MOD_LSB      8
`define CMSC_COD_LSB      16

// status register fields
`define CMSC_STAT_REJ     0
`define CMSC_STAT_RDY     1
`define CMSC_STAT_OVAL    2
`define CMSC_STAT_MSK     3

// reset values and fixed msk deviation
`define CMSC_DEV_RST      16'h0080
`define CMSC_PRBS_RST     9'h1FF
`define CMSC_MSK_DEV      16'h0100

// modulation types
`define CMSC_M_ASK        5'h00
`define CMSC_M_BPSK       5'h01
`define CMSC_M_DBPSK2     5'h02
`define CMSC_M_QPSK       5'h03
`define CMSC_M_QPSK_E     5'h04
`define CMSC_M_QPSK45     5'h05
`define CMSC_M_QPSK4      5'h06
`define CMSC_M_DQPSK4     5'h07
`define CMSC_M_PSK8       5'h08
`define CMSC_M_AQPSK      5'h09
`define CMSC_M_OQPSK      5'h0A
`define CMSC_M_PSK8_E     5'h0B
`define CMSC_M_D8PSK8     5'h0C
`define CMSC_M_MSK        5'h0D
`define CMSC_M_FSK2       5'h0E
`define CMSC_M_FSK4       5'h0F
`define CMSC_M_FSK8       5'h10
`define CMSC_M_FSK16      5'h11
`define CMSC_M_QAM16      5'h12
`define CMSC_M_QAM16_E    5'h13
`define CMSC_M_QAM32      5'h14
`define CMSC_M_QAM32_E    5'h15
`define CMSC_M_QAM64      5'h16
`define CMSC_M_QAM128     5'h17
`define CMSC_M_QAM256     5'h18
`define CMSC_M_QAM1024    5'h19
`define CMSC_M_VFSK       5'h1A
`define CMSC_M_USER       5'h1B

// symbol codings
`define CMSC_C_OFF        4'h0
`define CMSC_C_DIFF       4'h1
`define CMSC_C_PHDIFF     4'h2
`define CMSC_C_DGRAY      4'h3
`define CMSC_C_GRAY       4'h4
`define CMSC_C_GSM        4'h5
`define CMSC_C_NADC       4'h6
`define CMSC_C_TFTS       4'h7
`define CMSC_C_INMARSAT   4'h8
`define CMSC_C_VDL        4'h9
`define CMSC_C_APCO_FSK   4'hA
`define CMSC_C_APCO_8PSK  4'hB

`endif

// *** src/cmsc_buf.v ***
// two-entry output buffer with registered ready on the filling side
`timescale 1ns/100ps
module cmsc_buf #(
  parameter W = 50
) (
  // clock and reset
  input  wire         i_clk,
  input  wire         i_rst,
  // filling side
  input  wire         i_valid,
  input  wire [W-1:0] i_data,
  output reg          o_ready,
  // draining side
  output reg          o_valid,
  output reg  [W-1:0] o_data,
  input  wire         i_ready
);

  reg         skid_v_q;   // second entry holds a word
  reg [W-1:0] skid_d_q;   // second entry data
  wire        push;       // word taken this cycle
  wire        head_free;  // head empty or leaving

  assign push      = i_valid & o_ready;
  assign head_free = ~o_valid | i_ready;

  // head register feeds the output, skid catches a word during a stall
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_valid  <= 1'b0;
      o_data   <= {W{1'b0}};
      skid_v_q <= 1'b0;
      skid_d_q <= {W{1'b0}};
      o_ready  <= 1'b1;
    end
    else if (head_free)
    begin
      // head moves on: refill from skid first, keeping order
      if (skid_v_q)
      begin
        o_valid  <= 1'b1;
        o_data   <= skid_d_q;
        skid_v_q <= 1'b0;
        o_ready  <= 1'b1;
      end
      else
      begin
        o_valid <= push;
        if (push)
          o_data <= i_data;
        o_ready <= 1'b1;
      end
    end
    else if (push)
    begin
      // head stalled: park the word, stop the source
      skid_v_q <= 1'b1;
      skid_d_q <= i_data;
      o_ready  <= 1'b0;
    end
  end

endmodule

// *** src/cmsc_mapper.v ***
// symbol mapper: coded symbol to i/q values or frequency shift
`timescale 1ns/100ps
`include "cmsc_map.vh"
module cmsc_mapper (
  // clock and reset
  input  wire         i_clk,
  input  wire         i_rst,
  // symbol in
  input  wire         i_adv,
  input  wire [4:0]   i_mod,
  input  wire [3:0]   i_cod,
  input  wire [3:0]   i_bits,
  input  wire [9:0]   i_sym,
  // tables
  input  wire [15:0]  i_dev,
  input  wire [127:0] i_vdev,
  input  wire [383:0] i_user,
  // mapped value
  output reg  [11:0]  o_i,
  output reg  [11:0]  o_q,
  output reg  [15:0]  o_freq
);

  reg  [3:0]  phase_q;  // carrier phase in sixteenths of a turn
  reg  [3:0]  ph;       // phase for this symbol
  reg         psk;      // symbol is placed on the circle
  reg  [3:0]  ib;       // in-phase bits of a qam symbol
  reg  [16:0] prod;     // deviation times level
  reg  [11:0] lv;       // fsk level of this symbol

  // cosine of a sixteenth-turn phase, full scale 2047
  function [11:0] cos16;
    input [3:0] p;
    reg   [4:0] d;
    reg   [4:0] e;
    reg  [11:0] m;
    begin
      d = p[3] ? (5'h10 - {1'b0, p}) : {1'b0, p};
      e = (d > 5'h04) ? (5'h08 - d) : d;
      case (e)
        5'h00:   m = 12'h7FF;
        5'h01:   m = 12'h763;
        5'h02:   m = 12'h5A7;
        5'h03:   m = 12'h30F;
        default: m = 12'h000;
      endcase
      cos16 = (d > 5'h04) ? (12'h000 - m) : m;
    end
  endfunction

  // odd level 2v+1-2^nb scaled to full range
  function [11:0] axis;
    input [9:0] v;
    input [3:0] nb;
    reg  [11:0] t;
    begin
      t    = {1'b0, v, 1'b1} - (12'h001 << nb);
      axis = t << (4'hB - nb);
    end
  endfunction

  // phase step of a pi/4 dqpsk dibit for the active coding
  function [3:0] dq_step;
    input [1:0] s;
    input [3:0] c;
    begin
      if (c == `CMSC_C_TFTS)
        dq_step = (s == 2'h0) ? 4'hA : (s == 2'h1) ? 4'h6 : (s == 2'h2) ? 4'hE : 4'h2;
      else if (c == `CMSC_C_NADC)
        dq_step = (s == 2'h0) ? 4'h2 : (s == 2'h1) ? 4'h6 : (s == 2'h2) ? 4'hE : 4'hA;
      else
        dq_step = (s == 2'h0) ? 4'h2 : (s == 2'h1) ? 4'h6 : (s == 2'h2) ? 4'hA : 4'hE; // R15
    end
  endfunction

  // every symbol gets i/q or a frequency shift by type
  always @*
  begin
    ph     = 4'h0;
    psk    = 1'b0;
    o_i    = 12'h000;
    o_q    = 12'h000;
    o_freq = 16'h0000;
    ib     = (i_bits + 4'h1) >> 1;
    prod   = 17'h00000;
    lv     = axis(i_sym, i_bits);
    case (i_mod) // R05
      `CMSC_M_ASK:
        o_i = i_sym[0] ? 12'h7FF : 12'h000;
      `CMSC_M_BPSK:
      begin
        psk = 1'b1;
        ph  = {i_sym[0], 3'h0};
      end
      `CMSC_M_DBPSK2:
      begin
        psk = 1'b1;
        ph  = phase_q + (i_sym[0] ? 4'hC : 4'h4);
      end
      `CMSC_M_QPSK, `CMSC_M_QPSK_E, `CMSC_M_QPSK45, `CMSC_M_QPSK4,
      `CMSC_M_AQPSK, `CMSC_M_OQPSK:
      begin
        psk = 1'b1;
        ph  = {i_sym[1:0], 2'h2};
      end
      `CMSC_M_DQPSK4:
      begin
        psk = 1'b1;
        ph  = phase_q + dq_step(i_sym[1:0], i_cod); // R15
      end
      `CMSC_M_PSK8, `CMSC_M_PSK8_E:
      begin
        psk = 1'b1;
        ph  = {i_sym[2:0], 1'b0};
      end
      `CMSC_M_D8PSK8:
      begin
        psk = 1'b1;
        ph  = phase_q + {i_sym[2:0], 1'b1};
      end
      `CMSC_M_MSK:
        o_freq = i_sym[0] ? `CMSC_MSK_DEV : (16'h0000 - `CMSC_MSK_DEV); // R04
      `CMSC_M_FSK2, `CMSC_M_FSK4, `CMSC_M_FSK8, `CMSC_M_FSK16:
      begin
        prod   = ({1'b0, i_dev} * {{5{lv[11]}}, lv}) >> (4'hB - i_bits);
        o_freq = prod[15:0];
      end
      `CMSC_M_VFSK:
        o_freq = i_vdev[{i_sym[2:0], 4'h0} +: 16]; // R06
      `CMSC_M_USER:
      begin
        o_i = i_user[i_sym[3:0] * 24 +: 12]; // R07
        o_q = i_user[i_sym[3:0] * 24 + 12 +: 12];
      end
      default:
      begin
        // grid from i and q halves, square for even orders, one more i bit than q bits for qam32 and qam128
        o_i = axis(i_sym >> (i_bits - ib), ib); // R08
        o_q = axis(i_sym & ((10'h001 << (i_bits - ib)) - 10'h001), i_bits - ib);
      end
    endcase
    if (psk)
    begin
      o_i = cos16(ph);
      o_q = cos16(ph - 4'h4);
    end
  end

  // carrier phase follows each mapped symbol
  always @(posedge i_clk)
  begin
    if (i_rst)
      phase_q <= 4'h0;
    else if (i_adv)
      phase_q <= ph;
  end

endmodule

// *** src/cmsc_top.v ***
// custom modulation symbol coder: ahb-lite registers, coding, mapping, output buffer
//
// Behaviour
// R01 - coding applied just before symbol mapping
// R02 - refuse coding not permitted for modulation
// R03 - symbol bit zero is the lsb
// R04 - msk deviation fixed, deviation writes ignored
// R05 - i/q for psk/qam, shift for fsk
// R06 - variable fsk has per-symbol deviations
// R07 - user table may replace predefined mapping
// R08 - high qam orders follow the same grid
// R09 - prbs replaces external data during premeasurement
// R10 - gsm/vdl/inmarsat/apco8psk tied to one type
// R11 - edge types off only; restricted differential psks
// R12 - pi/4 dqpsk: off, gray, nadc, tfts
// R13 - differential: add previous output modulo 2^k
// R14 - differential-plus-gray: gray first, then differential
// R15 - uncoded pi/4 dqpsk phase steps table
// R16 - coding off passes symbol; state resets zero
`timescale 1ns/100ps
`include "cmsc_map.vh"
module cmsc_top (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_rst,
  // ahb-lite slave
  input  wire        i_hsel,
  input  wire [31:0] i_haddr,
  input  wire [1:0]  i_htrans,
  input  wire        i_hwrite,
  input  wire [2:0]  i_hsize,
  input  wire [31:0] i_hwdata,
  input  wire        i_hready,
  output reg  [31:0] o_hrdata,
  output reg         o_hreadyout,
  output reg         o_hresp,
  // symbol stream in
  input  wire        i_sym_valid,
  input  wire [9:0]  i_sym,
  output wire        o_sym_ready,
  // mapped stream out
  output wire        o_out_valid,
  output wire [9:0]  o_out_sym,
  output wire [11:0] o_out_i,
  output wire [11:0] o_out_q,
  output wire [15:0] o_out_freq,
  input  wire        i_out_ready
);

  // control and table registers
  reg  [4:0]   mod_q;      // modulation type
  reg  [3:0]   cod_q;      // symbol coding
  reg          pm_q;       // premeasurement running
  reg          rej_q;      // sticky refused pairing
  reg  [15:0]  dev_q;      // fsk deviation
  reg  [31:0]  cnt_q;      // symbols accepted
  reg  [127:0] vdev_q;     // variable fsk deviations
  reg  [383:0] user_q;     // user i/q table
  // ahb data phase
  reg          wr_q;       // write pending in data phase
  reg  [7:0]   wa_q;       // its word address
  // coder state
  reg  [9:0]   pb_q;       // previous coded symbol
  reg  [9:0]   pa_q;       // previous input symbol
  reg  [8:0]   prbs_q;     // substitute data generator
  // combinational
  reg  [9:0]   a;          // symbol before coding
  reg  [9:0]   b;          // coded symbol
  reg  [9:0]   g;          // gray form of a
  reg  [9:0]   m;          // k-bit mask
  reg  [1:0]   qd;         // quadrant sum for phase differential
  reg  [31:0]  rd;         // read mux
  wire [3:0]   k;          // bits per symbol
  wire         push;       // symbol taken
  wire         ahb_go;     // valid address phase
  wire         ctrl_wr;    // control register written
  wire [4:0]   nmod;       // requested type
  wire [3:0]   ncod;       // requested coding
  wire [11:0]  mi;         // mapped i
  wire [11:0]  mq;         // mapped q
  wire [15:0]  mf;         // mapped frequency

  // bits per symbol of a modulation type
  function [3:0] kbits;
    input [4:0] t;
    begin
      case (t)
        `CMSC_M_ASK, `CMSC_M_BPSK, `CMSC_M_DBPSK2, `CMSC_M_MSK, `CMSC_M_FSK2:
          kbits = 4'h1;
        `CMSC_M_PSK8, `CMSC_M_PSK8_E, `CMSC_M_D8PSK8, `CMSC_M_FSK8, `CMSC_M_VFSK:
          kbits = 4'h3;
        `CMSC_M_FSK16, `CMSC_M_QAM16, `CMSC_M_QAM16_E, `CMSC_M_USER:
          kbits = 4'h4;
        `CMSC_M_QAM32, `CMSC_M_QAM32_E:
          kbits = 4'h5;
        `CMSC_M_QAM64:   kbits = 4'h6;
        `CMSC_M_QAM128:  kbits = 4'h7;
        `CMSC_M_QAM256:  kbits = 4'h8;
        `CMSC_M_QAM1024: kbits = 4'hA;
        default:         kbits = 4'h2;
      endcase
    end
  endfunction

  // permitted codings of a modulation type, one bit per coding
  function ok_pair;
    input [4:0] t;
    input [3:0] c;
    reg  [11:0] pm;
    begin
      case (t)
        `CMSC_M_DBPSK2:  pm = 12'h011; // R11
        `CMSC_M_QPSK:    pm = 12'h11B; // R10
        `CMSC_M_QPSK_E, `CMSC_M_PSK8_E, `CMSC_M_QAM16_E, `CMSC_M_QAM32_E:
          pm = 12'h001; // R11
        `CMSC_M_QPSK4:   pm = 12'h013;
        `CMSC_M_DQPSK4:  pm = 12'h0D1; // R12
        `CMSC_M_PSK8:    pm = 12'h21B; // R10
        `CMSC_M_D8PSK8:  pm = 12'h811; // R11
        `CMSC_M_MSK:     pm = 12'h03B; // R10
        `CMSC_M_FSK4:    pm = 12'h41B;
        `CMSC_M_QAM16, `CMSC_M_QAM32, `CMSC_M_QAM64, `CMSC_M_QAM128,
        `CMSC_M_QAM256, `CMSC_M_QAM1024:
          pm = 12'h01F;
        `CMSC_M_USER, `CMSC_M_VFSK, `CMSC_M_ASK, `CMSC_M_BPSK, `CMSC_M_QPSK45,
        `CMSC_M_AQPSK, `CMSC_M_OQPSK, `CMSC_M_FSK2, `CMSC_M_FSK8, `CMSC_M_FSK16:
          pm = 12'h01B;
        default:         pm = 12'h000;
      endcase
      ok_pair = (c < 4'hC) ? pm[c] : 1'b0;
    end
  endfunction

  // phase step index of a vdl tribit
  function [2:0] vdl;
    input [2:0] d;
    begin
      case (d)
        3'h2:    vdl = 3'h3;
        3'h3:    vdl = 3'h2;
        3'h4:    vdl = 3'h6;
        3'h5:    vdl = 3'h7;
        3'h6:    vdl = 3'h5;
        3'h7:    vdl = 3'h4;
        default: vdl = d;
      endcase
    end
  endfunction

  assign k       = kbits(mod_q);
  assign push    = i_sym_valid & o_sym_ready;
  assign ahb_go  = i_hsel & i_htrans[1] & i_hready;
  assign ctrl_wr = wr_q & (wa_q == `CMSC_OFF_CTRL);
  assign nmod    = i_hwdata[`CMSC_MOD_LSB +: 5];
  assign ncod    = i_hwdata[`CMSC_COD_LSB +: 4];

  // coding is the last step before the mapper sees the symbol
  always @*
  begin
    m  = (10'h001 << k) - 10'h001;
    a  = (pm_q ? {1'b0, prbs_q} : i_sym) & m; // R09 R03
    g  = a ^ (a >> 1);
    qd = 2'h0;
    b  = a; // R16
    case (cod_q) // R01
      `CMSC_C_DIFF:
        b = (a + pb_q) & m; // R13
      `CMSC_C_DGRAY:
        b = (g + pb_q) & m; // R14
      `CMSC_C_GRAY:
        b = g & m;
      `CMSC_C_GSM:
        b = {9'h000, ~(a[0] ^ pa_q[0])};
      `CMSC_C_PHDIFF:
      begin
        // quadrant bits are differential, the rest pass
        qd = a[(k - 4'h2) +: 2] + pb_q[(k - 4'h2) +: 2];
        b  = (a & (m >> 2)) | ({8'h00, qd} << (k - 4'h2));
      end
      `CMSC_C_INMARSAT:
      begin
        b    = 10'h000;
        b[1] = (~(a[1] ^ a[0]) & (a[1] ^ pb_q[1])) | ((a[1] ^ a[0]) & (a[1] ^ pb_q[0]));
        b[0] = (~(a[1] ^ a[0]) & (a[0] ^ pb_q[0])) | ((a[1] ^ a[0]) & (a[0] ^ pb_q[1]));
      end
      `CMSC_C_VDL:
        b = {7'h00, vdl(a[2:0]) + pb_q[2:0]};
      default:
        b = a;
    endcase
  end

  // ahb address phase capture, read data and zero-wait answer
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wr_q        <= 1'b0;
      wa_q        <= 8'h00;
      o_hrdata    <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
    else
    begin
      wr_q <= ahb_go & i_hwrite;
      if (ahb_go)
        wa_q <= {i_haddr[7:2], 2'h0};
      if (ahb_go & ~i_hwrite)
        o_hrdata <= rd;
    end
  end

  // read mux, unmapped words read zero
  always @*
  begin
    rd = 32'h00000000;
    if (i_haddr[7:5] == `CMSC_VDEV_BASE)
      rd = {16'h0000, vdev_q[{i_haddr[4:2], 4'h0} +: 16]};
    else if (i_haddr[7:6] == `CMSC_USER_BASE)
      rd = {4'h0, user_q[i_haddr[5:2] * 24 + 12 +: 12], 4'h0, user_q[i_haddr[5:2] * 24 +: 12]};
    else
    begin
      case ({i_haddr[7:2], 2'h0})
        `CMSC_OFF_CTRL:
          rd = {12'h000, cod_q, 3'h0, mod_q, 6'h00, pm_q, 1'b0};
        `CMSC_OFF_STAT:
          rd = {28'h0000000, mod_q == `CMSC_M_MSK, o_out_valid, o_sym_ready, rej_q};
        `CMSC_OFF_DEV:
          rd = {16'h0000, (mod_q == `CMSC_M_MSK) ? `CMSC_MSK_DEV : dev_q}; // R04
        `CMSC_OFF_CNT:
          rd = cnt_q;
        default:
          rd = 32'h00000000;
      endcase
    end
  end

  // register writes in the data phase
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      mod_q  <= `CMSC_M_BPSK;
      cod_q  <= `CMSC_C_OFF;
      pm_q   <= 1'b0;
      rej_q  <= 1'b0;
      dev_q  <= `CMSC_DEV_RST;
      vdev_q <= 128'h0;
      user_q <= 384'h0;
    end
    else
    begin
      if (ctrl_wr)
      begin
        pm_q <= i_hwdata[`CMSC_CTRL_PM];
        if (ok_pair(nmod, ncod))
        begin
          mod_q <= nmod; // R02
          cod_q <= ncod;
        end
      end
      // refusal is sticky; a new refusal beats a clear in the same write
      if (ctrl_wr & ~ok_pair(nmod, ncod))
        rej_q <= 1'b1; // R02
      else if (wr_q & (wa_q == `CMSC_OFF_STAT) & i_hwdata[`CMSC_STAT_REJ])
        rej_q <= 1'b0;
      if (wr_q & (wa_q == `CMSC_OFF_DEV) & (mod_q != `CMSC_M_MSK))
        dev_q <= i_hwdata[15:0]; // R04
      if (wr_q & (wa_q[7:5] == `CMSC_VDEV_BASE))
        vdev_q[{wa_q[4:2], 4'h0} +: 16] <= i_hwdata[15:0]; // R06
      if (wr_q & (wa_q[7:6] == `CMSC_USER_BASE))
        user_q[wa_q[5:2] * 24 +: 24] <= {i_hwdata[27:16], i_hwdata[11:0]}; // R07
    end
  end

  // differential state, prbs and symbol count advance per taken symbol
  always @(posedge i_clk)
  begin
    if (i_rst | ctrl_wr)
    begin
      pb_q <= 10'h000; // R16
      pa_q <= 10'h000;
    end
    else if (push)
    begin
      pb_q <= b; // R13
      pa_q <= a;
    end
    if (i_rst)
    begin
      prbs_q <= `CMSC_PRBS_RST;
      cnt_q  <= 32'h00000000;
    end
    else if (push)
    begin
      prbs_q <= {prbs_q[7:0], prbs_q[8] ^ prbs_q[4]}; // R09
      cnt_q  <= cnt_q + 32'h00000001;
    end
  end

  // mapper takes the coded symbol in the same cycle
  cmsc_mapper u_map (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_adv  (push),
    .i_mod  (mod_q),
    .i_cod  (cod_q),
    .i_bits (k),
    .i_sym  (b),
    .i_dev  (dev_q),
    .i_vdev (vdev_q),
    .i_user (user_q),
    .o_i    (mi),
    .o_q    (mq),
    .o_freq (mf)
  );

  // buffer absorbs a stall downstream without losing a word
  cmsc_buf #(
    .W (50)
  ) u_buf (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_valid (i_sym_valid),
    .i_data  ({b, mi, mq, mf}),
    .o_ready (o_sym_ready),
    .o_valid (o_out_valid),
    .o_data  ({o_out_sym, o_out_i, o_out_q, o_out_freq}),
    .i_ready (i_out_ready)
  );

endmodule

// *** verif/cmsc_top_sva.sv ***
// port-level assertion checker for the symbol coder
`timescale 1ns/100ps
module cmsc_top_chk (
  // clock and reset
  input logic        i_clk,
  input logic        i_rst,
  // register bus
  input logic        i_hsel,
  input logic [31:0] i_haddr,
  input logic [1:0]  i_htrans,
  input logic        i_hwrite,
  input logic        i_hready,
  input logic [31:0] o_hrdata,
  input logic        o_hreadyout,
  input logic        o_hresp,
  // symbol streams
  input logic        i_sym_valid,
  input logic        o_sym_ready,
  input logic        o_out_valid,
  input logic [9:0]  o_out_sym,
  input logic [11:0] o_out_i,
  input logic [11:0] o_out_q,
  input logic [15:0] o_out_freq,
  input logic        i_out_ready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // read address phase accepted at this edge
  wire rd_ap = i_hsel && i_htrans[1] && !i_hwrite && i_hready;
  // stalled output word
  wire stall = o_out_valid && !i_out_ready;

  AST_RST_OUT: assert property ($fell(i_rst) |-> !o_out_valid && o_sym_ready
    && o_hrdata == 32'h0) else $error("reset outputs wrong");
  AST_RESP_OK: assert property (o_hresp == 1'b0 && o_hreadyout == 1'b1)
    else $error("bus answer not okay");
  AST_UNMAPPED: assert property (rd_ap && i_haddr[7:6] == 2'b11 |=> o_hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_RD_HOLD: assert property (!rd_ap |=> $stable(o_hrdata))
    else $error("read data moved");
  AST_FIRST_OUT: assert property (i_sym_valid && o_sym_ready && !o_out_valid
    |=> o_out_valid) else $error("taken symbol not shown");
  AST_SYM_HOLD: assert property (stall |=> o_out_valid && $stable(o_out_sym))
    else $error("stalled symbol changed");
  AST_MAP_HOLD: assert property (stall |=> $stable({o_out_i, o_out_q, o_out_freq}))
    else $error("stalled map changed");
  AST_RDY_DROP: assert property ($fell(o_sym_ready) |-> $past(stall))
    else $error("ready fell unstalled");
endmodule

// *** verif/cmsc_sink.sv ***
// downstream filter model: takes output words, stalls on request
`timescale 1ns/100ps
module cmsc_sink (
  // clock and reset
  input  wire       i_clk,
  input  wire       i_rst,
  // bench control: 0 always ready, 1 random stalls, 2 hold off
  input  wire [1:0] i_mode,
  // stream handshake
  output reg        o_ready
);
  reg [7:0] pat_q; // stall pattern shift register

  // ready moves just after an edge
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pat_q   <= 8'hA5;
      o_ready <= 1'b1;
    end
    else
    begin
      pat_q   <= {pat_q[6:0], pat_q[7] ^ pat_q[5] ^ pat_q[4] ^ pat_q[3]};
      o_ready <= (i_mode == 2'h0) || (i_mode == 2'h1 && pat_q[1:0] != 2'h0);
    end
  end
endmodule

// *** verif/tb_cmsc_top.sv ***
// self-checking bench for the symbol coder
`timescale 1ns/100ps
`include "cmsc_map.vh"
module tb_cmsc_top;
  logic        i_clk       = 1'b0;
  logic        i_rst       = 1'b1;
  logic        i_hsel      = 1'b0;
  logic [31:0] i_haddr     = 32'h0;
  logic [1:0]  i_htrans    = 2'h0;
  logic        i_hwrite    = 1'b0;
  logic [2:0]  i_hsize     = 3'h2;
  logic [31:0] i_hwdata    = 32'h0;
  logic        i_sym_valid = 1'b0;
  logic [9:0]  i_sym       = 10'h0;
  logic [1:0]  sink_mode   = 2'h0;   // far-side stall mode
  wire         i_hready, o_hreadyout, o_hresp, o_sym_ready, o_out_valid, i_out_ready;
  wire  [31:0] o_hrdata;
  wire  [9:0]  o_out_sym;
  wire  [11:0] o_out_i, o_out_q;
  wire  [15:0] o_out_freq;
  logic [35:0] exp_q [$];            // {check iq, check sym, sym, i, q}
  logic [35:0] ew;                   // note taken off the queue
  logic [31:0] rd, cur;              // read data, control value expected to stand
  logic [7:0]  ur [16];              // random byte behind each user table entry
  logic [7:0]  rnd = 8'h46;          // random state
  logic [9:0]  prev;                 // coded symbol model
  int          errors = 0, n_compared = 0, n_sent = 0, j;
  // {legal, modulation code, coding code} per entry
  logic [9:0]  pairs [20] = '{10'h2D5, 10'h0E5, 10'h289, 10'h039, 10'h238, 10'h088, 10'h2CB,
    10'h08B, 10'h044, 10'h2B0, 10'h0B1, 10'h021, 10'h224, 10'h071, 10'h073, 10'h276, 10'h277,
    10'h0C1, 10'h2C4, 10'h231};

  always #5 i_clk = ~i_clk;
  assign i_hready = o_hreadyout;

  cmsc_top dut_u (.i_clk, .i_rst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize,
    .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .i_sym_valid, .i_sym,
    .o_sym_ready, .o_out_valid, .o_out_sym, .o_out_i, .o_out_q, .o_out_freq, .i_out_ready);
  cmsc_sink sink_u (.i_clk, .i_rst, .i_mode(sink_mode), .o_ready(i_out_ready));

  function logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task stop_test;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task timeout;
    errors++;
    $display("mismatch wait expected handshake seen timeout");
    stop_test();
  endtask

  task check(input string what, input logic [31:0] x, got);
    n_compared++;
    if (got !== x)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, x, got);
    end
  endtask

  // bounded wait for the slave's ready at an edge
  task edge_rdy;
    int k;
    k = 0;
    do
      @(posedge i_clk);
    while (o_hreadyout !== 1'b1 && ++k < 100);
    if (o_hreadyout !== 1'b1)
      timeout();
  endtask

  // one single word transfer: address phase, then data phase
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    i_hsel   <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr  <= {24'h0, a};
    i_hwrite <= w;
    edge_rdy();
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    edge_rdy();
    d = o_hrdata;
  endtask

  task rchk(input string what, input logic [7:0] a, input logic [31:0] m, x);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    check(what, x, d & m);
  endtask

  // control write; any control write clears the coding state
  task cfg(input logic [4:0] m, input logic [3:0] c, input logic pm);
    bus(1'b1, `CMSC_OFF_CTRL, {12'h0, c, 3'h0, m, 6'h0, pm, 1'b0}, rd);
    prev = 10'h0;
  endtask

  // offer one symbol, note its expectation when taken
  task send(input logic [9:0] s, input logic [35:0] e);
    int k;
    i_sym_valid <= 1'b1;
    i_sym       <= s;
    k = 0;
    do
      @(posedge i_clk);
    while (o_sym_ready !== 1'b1 && ++k < 100);
    if (o_sym_ready !== 1'b1)
      timeout();
    exp_q.push_back(e);
    n_sent++;
  endtask

  task drain;
    int k;
    i_sym_valid <= 1'b0;
    sink_mode   <= 2'h0;
    for (k = 0; k < 200 && exp_q.size() != 0; k++)
      @(posedge i_clk);
    if (exp_q.size() != 0)
      timeout();
  endtask

  // random burst under random stalls, model of the selected coding
  task burst(input logic [4:0] m, input logic [3:0] c, input int nb);
    logic [9:0] a, g, msk;
    cfg(m, c, 1'b0);
    sink_mode <= 2'h1;
    msk = (10'h1 << nb) - 10'h1;
    for (j = 0; j < 24; j++)
    begin
      rnd = lfsr(rnd);
      a = {2'h0, rnd} & msk;
      g = (c == `CMSC_C_DGRAY) ? (a ^ (a >> 1)) : a;
      prev = (c == `CMSC_C_OFF) ? g : ((g + prev) & msk);
      send(a, {2'b01, prev, 24'h0});
    end
    drain();
  endtask

  // scoreboard: oldest note against each word the far side takes
  always @(posedge i_clk)
  begin
    if (i_rst === 1'b0 && o_out_valid === 1'b1 && i_out_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        errors++;
        $display("mismatch out word expected none seen %h", o_out_sym);
      end
      else
      begin
        ew = exp_q.pop_front();
        if (ew[34])
          check("out symbol", ew[33:24], o_out_sym);
        if (ew[35])
          check("out i q", ew[23:0], {o_out_i, o_out_q});
      end
    end
  end

  initial
  begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    rchk("ctrl", `CMSC_OFF_CTRL, '1, 32'h100);
    rchk("dev", `CMSC_OFF_DEV, '1, {16'h0, `CMSC_DEV_RST});
    rchk("count", `CMSC_OFF_CNT, '1, 32'h0);
    rchk("unmapped", 8'hF0, '1, 32'h0);
    rchk("stat", `CMSC_OFF_STAT, 32'hF, 32'h2);
    $display("test reset values done");
    cfg(`CMSC_M_MSK, `CMSC_C_OFF, 1'b0);
    bus(1'b1, `CMSC_OFF_DEV, 32'h1234, rd);
    rchk("msk dev", `CMSC_OFF_DEV, 32'hFFFF, {16'h0, `CMSC_MSK_DEV});
    cfg(`CMSC_M_QPSK, `CMSC_C_OFF, 1'b0);
    rchk("dev kept", `CMSC_OFF_DEV, 32'hFFFF, {16'h0, `CMSC_DEV_RST});
    bus(1'b1, `CMSC_OFF_DEV, 32'h1234, rd);
    rchk("dev set", `CMSC_OFF_DEV, 32'hFFFF, 32'h1234);
    $display("test msk deviation done");
    cur = 32'h00000300;
    for (j = 0; j < 20; j++)
    begin
      bus(1'b1, `CMSC_OFF_CTRL, {12'h0, pairs[j][3:0], 3'h0, pairs[j][8:4], 8'h0}, rd);
      if (pairs[j][9])
        cur = {12'h0, pairs[j][3:0], 3'h0, pairs[j][8:4], 8'h0};
      rchk("refused", `CMSC_OFF_STAT, 32'h9,
        {28'h0, cur[12:8] == `CMSC_M_MSK, 2'h0, !pairs[j][9]});
      rchk("ctrl kept", `CMSC_OFF_CTRL, 32'h000F1F02, cur);
      bus(1'b1, `CMSC_OFF_STAT, 32'h1, rd);
    end
    $display("test coding permissions done");
    burst(`CMSC_M_QPSK, `CMSC_C_OFF, 2);
    burst(`CMSC_M_QPSK, `CMSC_C_DIFF, 2);
    burst(`CMSC_M_BPSK, `CMSC_C_DIFF, 1);
    burst(`CMSC_M_PSK8, `CMSC_C_DGRAY, 3);
    $display("test coding streams done");
    cfg(`CMSC_M_QPSK, `CMSC_C_OFF, 1'b0);
    sink_mode <= 2'h2;
    send(10'h1, {2'b01, 10'h1, 24'h0});
    send(10'h2, {2'b01, 10'h2, 24'h0});
    i_sym_valid <= 1'b0;
    rchk("buffer full", `CMSC_OFF_STAT, 32'h6, 32'h4);
    drain();
    $display("test buffer stall done");
    for (j = 0; j < 16; j++)
    begin
      rnd = lfsr(rnd);
      ur[j] = rnd;
      bus(1'b1, 8'h80 + 8'(j * 4), {8'h05, rnd, 4'h0, rnd, 4'hA}, rd);
    end
    cfg(`CMSC_M_USER, `CMSC_C_OFF, 1'b0);
    for (j = 0; j < 16; j++)
      send(10'(j), {2'b11, 10'(j), ur[j], 8'hA5, ur[j]});
    drain();
    cfg(`CMSC_M_DQPSK4, `CMSC_C_OFF, 1'b0);
    send(10'h0, {2'b10, 10'h0, 24'h5A75A7});
    drain();
    $display("test user mapping done");
    cfg(`CMSC_M_QPSK, `CMSC_C_OFF, 1'b1);
    for (j = 0; j < 8; j++)
      send(10'(j & 3), 36'h0);
    drain();
    rchk("count", `CMSC_OFF_CNT, 32'hFFFFFFFF, n_sent);
    $display("test premeasurement done");
    stop_test();
  end
endmodule

bind cmsc_top cmsc_top_chk chk_u (.i_clk, .i_rst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
  .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .i_sym_valid, .o_sym_ready, .o_out_valid,
  .o_out_sym, .o_out_i, .o_out_q, .o_out_freq, .i_out_ready);
